// [verilog/thermal_guard_pkg.sv]
// Constants shared by the over-temperature fault logic: serial command codes,
// field positions inside the 24-bit data part of a frame and reset values.
// Assumes 32-bit frames: one command byte followed by three data bytes.
package thermal_guard_pkg;

   // Channel count and frame geometry
   localparam int unsigned NUM_CHANNELS  = 8;
   localparam int unsigned FRAME_BITS    = 32;
   localparam int unsigned DATA_BITS     = 24;
   localparam logic [5:0]  LAST_BIT_IDX  = 6'h1F;
   localparam logic [5:0]  FRAME_DONE    = 6'h20;

   // Analog comparator thresholds in degrees Celsius (set in the sensors)
   localparam int unsigned TRIP_DEG_C    = 160;
   localparam int unsigned RELEASE_DEG_C = 150;

   // Command byte codes
   localparam logic [7:0] CMD_CONFIG_WR  = 8'h70;   // Command 7
   localparam logic [7:0] CMD_PD_WR      = 8'h71;   // Command 8
   localparam logic [7:0] CMD_FAULT_WR   = 8'h76;   // Command 13
   localparam logic [7:0] CMD_CONFIG_RD  = 8'hF0;   // Command 24
   localparam logic [7:0] CMD_PD_RD      = 8'hF1;   // Command 25
   localparam logic [7:0] CMD_FAULT_RD   = 8'hF6;   // Command 30
   localparam logic [7:0] CMD_STATUS_RD  = 8'hF7;   // Command 31

   // Field positions inside the 24-bit data part
   localparam int unsigned CFG_RST_BIT   = 23;
   localparam int unsigned CFG_GUARD_BIT = 10;
   localparam int unsigned CFG_EXTREF_BIT= 9;
   localparam int unsigned CFG_CRC_BIT   = 8;
   localparam int unsigned FLT_TSF_BIT   = 10;
   localparam int unsigned FLT_CKF_BIT   = 9;
   localparam int unsigned FLT_CF_BIT    = 8;
   localparam int unsigned CHAN_BIT_BASE = 8;       // Channel x sits at base + 2x
   localparam int unsigned CHAN_BIT_STEP = 2;

   // Reset values
   localparam logic [7:0]  CHAN_RESET    = 8'h00;
   localparam logic [31:0] RESP_RESET    = 32'h0000_0000;
   localparam logic        GUARD_RESET   = 1'b0;

endpackage

// [verilog/level_sync.sv]
// Two-flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level or a toggle; bits are not coherent words.
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Levels in and out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_s;

   sync_s cur_ff;
   sync_s nxt_ff;

   // Stage one feeds stage two only, to let metastability settle
   always_comb begin
      nxt_ff        = cur_ff;
      nxt_ff.stage1 = async_in;
      nxt_ff.stage2 = cur_ff.stage1;
   end

   // Constant reset; the inputs are caught only after release
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   assign sync_out = cur_ff.stage2;

endmodule
`default_nettype wire

// [verilog/thermal_shutdown_fault_logic.sv]
// Per-channel over-temperature shutdown, fault flag, alarm pin and serial access.
// Assumes one comparator pair per channel (above trip, below release), a serial
// host with link_clk low at rest, and frames framed by select_load low.
`timescale 1ns/1ps
`default_nettype none
module thermal_shutdown_fault_logic
   import thermal_guard_pkg::*;
#(
   parameter int unsigned CHANNELS = NUM_CHANNELS
) (
   // System clock and reset
   input  wire logic                clk,
   input  wire logic                reset_n,
   // Serial link
   input  wire logic                link_clk,
   input  wire logic                select_load,
   input  wire logic                serial_in,
   output logic                     serial_out,
   // Device clear pin, active low
   input  wire logic                clear_pin_n,
   // Temperature comparators per channel
   input  wire logic [CHANNELS-1:0] over_trip_in,
   input  wire logic [CHANNELS-1:0] below_release_in,
   // Channel and chip power control
   output logic      [CHANNELS-1:0] channel_off,
   output logic                     chip_off,
   // Open-drain alarm and fault flag
   output logic                     alarm_n_out,
   output logic                     alarm_n_oe,
   output logic                     overheat_flag
);

   // Width and slot positions of the synchroniser vector
   localparam int unsigned SYNC_W   = 2 * CHANNELS + 3;
   localparam int unsigned SYNC_CLR = SYNC_W - 1;
   localparam int unsigned SYNC_CS  = SYNC_W - 2;
   localparam int unsigned SYNC_TOG = SYNC_W - 3;

   // Spread channel bits over the interleaved layout, channel x at base + 2x
   function automatic logic [DATA_BITS-1:0] pack_chan(input logic [CHANNELS-1:0] bits);
      logic [DATA_BITS-1:0] word;
      word = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         word[CHAN_BIT_BASE + CHAN_BIT_STEP * i] = bits[i];
      end
      return word;
   endfunction

   // Gather channel bits back out of the interleaved layout
   function automatic logic [CHANNELS-1:0] unpack_chan(input logic [DATA_BITS-1:0] word);
      logic [CHANNELS-1:0] bits;
      bits = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         bits[i] = word[CHAN_BIT_BASE + CHAN_BIT_STEP * i];
      end
      return bits;
   endfunction

   // Link side, rising edge: bit counter cleared by the frame's own strobe
   typedef struct packed {
      logic [5:0] count;
   } frame_s;

   // Link side, rising edge: shift register and the last complete word
   typedef struct packed {
      logic [FRAME_BITS-2:0] shift;
      logic [FRAME_BITS-1:0] held;
      logic                  tog;
   } link_in_s;

   // Link side, falling edge: answer shifter
   typedef struct packed {
      logic [FRAME_BITS-1:0] out;
      logic                  loaded;
   } link_out_s;

   // System side state
   typedef struct packed {
      // Frame handshake and strobe edge detect
      logic                  tog_seen;
      logic                  cs_prev;
      // Register contents
      logic [CHANNELS-1:0]   power_down;
      logic [CHANNELS-1:0]   channel_overheat_bit;
      logic                  overheat_flag;
      logic                  guard_off;
      logic                  ext_ref;
      logic                  crc_en;
      // Pin state and the answer for the next frame
      logic                  alarm_on;
      logic                  chip_off;
      logic [FRAME_BITS-1:0] resp;
   } core_s;

   // State registers and their next values
   frame_s    frame_ff;
   frame_s    nxt_frame_ff;
   link_in_s  lin_ff;
   link_in_s  nxt_lin_ff;
   link_out_s lout_ff;
   link_out_s nxt_lout_ff;
   core_s     core_ff;
   core_s     nxt_core_ff;

   // Frame reset and synchronised levels
   logic                frame_rst_n;
   logic [SYNC_W-1:0]   sync_vec;
   logic                s_clear_n;
   logic                s_cs;
   logic                s_tog;
   logic [CHANNELS-1:0] s_hot;
   logic [CHANNELS-1:0] s_cool;

   // The counter and answer shifter restart whenever select_load is high, so
   // nothing depends on link_clk edges outside a frame
   assign frame_rst_n = reset_n & ~select_load;

   // Count bits of the frame, saturating after the last one
   always_comb begin
      nxt_frame_ff = frame_ff;
      // Saturation keeps bits past the last one from being counted
      if (frame_ff.count != FRAME_DONE) begin
         nxt_frame_ff.count = frame_ff.count + 6'h01;
      end
   end

   // Counter restarts with every frame strobe
   always_ff @(posedge link_clk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         frame_ff <= '0;
      end else begin
         frame_ff <= nxt_frame_ff;
      end
   end

   // Shift in data; the completed word is held until the next full frame,
   // so the system side may read it after the toggle has crossed
   always_comb begin
      nxt_lin_ff = lin_ff;
      if (frame_ff.count != FRAME_DONE) begin
         nxt_lin_ff.shift = {lin_ff.shift[FRAME_BITS-3:0], serial_in};
      end
      if (frame_ff.count == LAST_BIT_IDX) begin
         nxt_lin_ff.held = {lin_ff.shift, serial_in};
         nxt_lin_ff.tog  = ~lin_ff.tog;
      end
   end

   // Held word and toggle survive the strobe; only a power-up reset clears them
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         lin_ff <= '0;
      end else begin
         lin_ff <= nxt_lin_ff;
      end
   end

   // Answer shifter: bit 31 of the answer is always zero, which is what the
   // cleared shifter shows before the first falling edge; the rest follows
   always_comb begin
      nxt_lout_ff = lout_ff;
      if (!lout_ff.loaded) begin
         nxt_lout_ff.out    = {core_ff.resp[FRAME_BITS-2:0], 1'b0};
         nxt_lout_ff.loaded = 1'b1;
      end else begin
         nxt_lout_ff.out = {lout_ff.out[FRAME_BITS-2:0], 1'b0};
      end
   end

   // Falling edge launches each answer bit half a period before the host samples
   always_ff @(negedge link_clk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         lout_ff <= '0;
      end else begin
         lout_ff <= nxt_lout_ff;
      end
   end

   assign serial_out = lout_ff.out[FRAME_BITS-1];

   // Pins and the frame toggle cross into the system clock here. The clear pin
   // and the strobe enter inverted, so the cleared synchroniser matches their
   // idle high level and no false clear or strobe edge follows a reset
   level_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in ({~clear_pin_n, ~select_load, lin_ff.tog, over_trip_in, below_release_in}),
      .sync_out (sync_vec)
   );

   // The held word is stable for a whole frame, so the toggle alone qualifies it
   assign s_clear_n = ~sync_vec[SYNC_CLR];
   assign s_cs      = ~sync_vec[SYNC_CS];
   assign s_tog     = sync_vec[SYNC_TOG];
   assign s_hot     = sync_vec[2*CHANNELS-1:CHANNELS];
   assign s_cool    = sync_vec[CHANNELS-1:0];

   // Command decode, latching and recovery; hardware sets always win over clears
   always_comb begin
      logic                 cmd_go;
      logic [7:0]           cmd;
      logic [DATA_BITS-1:0] dat;
      logic                 all_cool;
      logic                 rst_req;
      logic [CHANNELS-1:0]  trip;
      logic [CHANNELS-1:0]  new_trip;
      nxt_core_ff = core_ff;
      // Decode the held frame and summarise the sensors
      cmd         = lin_ff.held[FRAME_BITS-1:DATA_BITS];
      dat         = lin_ff.held[DATA_BITS-1:0];
      cmd_go      = (s_tog != core_ff.tog_seen);
      all_cool    = &s_cool;
      // Guard off masks trips on every channel, down or not; channels already down stay down
      trip        = s_hot & ~{CHANNELS{core_ff.guard_off}};
      new_trip    = trip & ~core_ff.power_down;
      rst_req     = ~s_clear_n
                  | (cmd_go && (cmd == CMD_CONFIG_WR) && dat[CFG_RST_BIT]);

      // Levels kept for the toggle and strobe edge detectors
      nxt_core_ff.tog_seen = s_tog;
      nxt_core_ff.cs_prev  = s_cs;

      // Writes and reads taken from a complete frame
      if (cmd_go) begin
         nxt_core_ff.resp = RESP_RESET;
         case (cmd)
            CMD_CONFIG_WR: begin
               nxt_core_ff.guard_off = dat[CFG_GUARD_BIT];
               nxt_core_ff.ext_ref   = dat[CFG_EXTREF_BIT];
               nxt_core_ff.crc_en    = dat[CFG_CRC_BIT];
            end
            CMD_FAULT_WR: begin
               nxt_core_ff.overheat_flag = dat[FLT_TSF_BIT];
            end
            CMD_PD_WR: begin
               // Releasing a channel needs a cleared flag and a cool die
               if (all_cool && !core_ff.overheat_flag) begin
                  nxt_core_ff.power_down = unpack_chan(dat);
               end else begin
                  // Otherwise only new ones are taken, added to what is down
                  nxt_core_ff.power_down = core_ff.power_down | unpack_chan(dat);
               end
            end
            CMD_CONFIG_RD: begin
               nxt_core_ff.resp[CFG_GUARD_BIT]  = core_ff.guard_off;
               nxt_core_ff.resp[CFG_EXTREF_BIT] = core_ff.ext_ref;
               nxt_core_ff.resp[CFG_CRC_BIT]    = core_ff.crc_en;
            end
            CMD_PD_RD: begin
               nxt_core_ff.resp[DATA_BITS-1:0] = pack_chan(core_ff.power_down);
            end
            CMD_FAULT_RD: begin
               nxt_core_ff.resp[FLT_TSF_BIT] = core_ff.overheat_flag;
               nxt_core_ff.resp[FLT_CKF_BIT] = 1'b0;               // No clock fault source in this block
               nxt_core_ff.resp[FLT_CF_BIT]  = 1'b0;               // CRC is stored, never checked
            end
            CMD_STATUS_RD: begin
               // Odd bits and byte 3 read as zero
               nxt_core_ff.resp[DATA_BITS-1:0] = pack_chan(core_ff.channel_overheat_bit);
            end
            default: begin
            end
         endcase
      end

      // Soft reset and clear pin restore defaults; channels restart only cool
      if (rst_req) begin
         nxt_core_ff.guard_off     = GUARD_RESET;
         nxt_core_ff.ext_ref       = 1'b0;
         nxt_core_ff.crc_en        = 1'b0;
         nxt_core_ff.overheat_flag = 1'b0;
         nxt_core_ff.resp          = RESP_RESET;
         // Unless every channel is cool, all channels keep their bits, so a clear never hides a live trip
         if (all_cool) begin
            nxt_core_ff.power_down           = CHAN_RESET;
            nxt_core_ff.channel_overheat_bit = CHAN_RESET;
         end
      end

      // Alarm is released by a select_load rising edge
      // Released on the synchronised edge; a trip in the same cycle is applied later
      if (s_cs && !core_ff.cs_prev) begin
         nxt_core_ff.alarm_on = 1'b0;
      end

      // Trips are applied last so they win over any clear in the same cycle
      nxt_core_ff.power_down           = nxt_core_ff.power_down | trip;
      nxt_core_ff.channel_overheat_bit = nxt_core_ff.channel_overheat_bit | trip;
      if (|trip) begin
         nxt_core_ff.overheat_flag = 1'b1;
      end
      if (|new_trip) begin
         nxt_core_ff.alarm_on = 1'b1;
      end

      // Whole chip goes down only once every channel is down
      nxt_core_ff.chip_off = &nxt_core_ff.power_down;
   end

   // System side registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         core_ff          <= '0;
         core_ff.cs_prev  <= 1'b1;
      end else begin
         core_ff <= nxt_core_ff;
      end
   end

   // Outputs straight from flip-flops, alarm_n_out through an inverter; one enable serves the alarm for all channels
   assign channel_off   = core_ff.power_down;
   assign chip_off      = core_ff.chip_off;
   // The pin is open drain: the enable pulls it low, the value only mirrors it
   assign alarm_n_out   = ~core_ff.alarm_on;
   assign alarm_n_oe    = core_ff.alarm_on;
   assign overheat_flag = core_ff.overheat_flag;

endmodule
`default_nettype wire

// [testbench/thermal_props.sv]
// Checker for the over-temperature fault logic; it sees only the top ports.
// Assumes the bench keeps sensor levels steady around the end of each frame.
`timescale 1ns/1ps
`default_nettype none
module thermal_props
   import thermal_guard_pkg::*;
#(
   parameter int unsigned CHANNELS = NUM_CHANNELS
) (
   // Clock and reset
   input wire logic                clk,
   input wire logic                reset_n,
   // Serial link
   input wire logic                link_clk,
   input wire logic                select_load,
   input wire logic                serial_in,
   input wire logic                serial_out,
   // Clear pin and sensors
   input wire logic                clear_pin_n,
   input wire logic [CHANNELS-1:0] over_trip_in,
   input wire logic [CHANNELS-1:0] below_release_in,
   // Power, alarm and flag
   input wire logic [CHANNELS-1:0] channel_off,
   input wire logic                chip_off,
   input wire logic                alarm_n_out,
   input wire logic                alarm_n_oe,
   input wire logic                overheat_flag
);
   // All checks run in the system clock domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // chip_off is registered from the same next value as the power-down bits
   property p_chip; chip_off == (&channel_off); endproperty
   a_chip: assert property (p_chip) else $error("chip_off not following channel_off");
   // Cooling below release is seen through a sync pipeline, hence the depth spread
   property p_latch;
      |($past(channel_off) & ~channel_off) |->
         $past(&below_release_in, 2) || $past(&below_release_in, 3) || $past(&below_release_in, 4);
   endproperty
   a_latch: assert property (p_latch) else $error("channel released while hot");
   // A new trip caught in the release cycle keeps the alarm on, so sensors must hold still
   property p_release;
      $rose(select_load) && $stable(over_trip_in) ##1 $stable(over_trip_in)[*3] |-> ##[0:2] !alarm_n_oe;
   endproperty
   a_release: assert property (p_release) else $error("alarm kept after frame end");
   property p_wire; alarm_n_out == !alarm_n_oe; endproperty
   a_wire: assert property (p_wire) else $error("alarm pin value and enable disagree");
   property p_trip; $rose(alarm_n_oe) |-> overheat_flag && (|channel_off); endproperty
   a_trip: assert property (p_trip) else $error("alarm without flag and channel off");
   property p_sdo; select_load && $past(select_load) |-> !serial_out; endproperty
   a_sdo: assert property (p_sdo) else $error("serial_out driven outside frame");
   property p_first; $rose(reset_n) |-> alarm_n_out && !alarm_n_oe && !overheat_flag; endproperty
   a_first: assert property (p_first) else $error("bad state after reset");
   property p_clr_flag; (!clear_pin_n && over_trip_in == '0)[*4] |-> !overheat_flag; endproperty
   a_clr_flag: assert property (p_clr_flag) else $error("flag kept under clear pin");
   property p_clr_chan;
      (!clear_pin_n && over_trip_in == '0 && (&below_release_in))[*4] |-> channel_off == '0;
   endproperty
   a_clr_chan: assert property (p_clr_chan) else $error("channels kept off under clear pin");
   // Main scenarios reached
   c_chip: cover property (chip_off);
   c_alarm: cover property (alarm_n_oe ##1 !alarm_n_oe);
   c_clear: cover property (!clear_pin_n ##1 !clear_pin_n);
endmodule
bind thermal_shutdown_fault_logic thermal_props #(.CHANNELS(CHANNELS)) props (
   .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .select_load(select_load), .serial_in(serial_in),
   .serial_out(serial_out), .clear_pin_n(clear_pin_n), .over_trip_in(over_trip_in),
   .below_release_in(below_release_in), .channel_off(channel_off), .chip_off(chip_off),
   .alarm_n_out(alarm_n_out), .alarm_n_oe(alarm_n_oe), .overheat_flag(overheat_flag));
`default_nettype wire

// [testbench/spi_host_model.sv]
// Serial host model: shifts 32-bit frames and captures the answer.
// Assumes the device samples on link_clk rising and shifts out on falling.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Link toward the device
   output logic      link_clk,
   output logic      select_load,
   output logic      serial_in,
   input  wire logic serial_out
);
   // Clock stands still low between frames
   initial begin
      link_clk = 1'b0;
      select_load = 1'b1;
      serial_in = 1'b0;
   end
   // Command byte then three data bytes, MSB first; answer of the previous frame comes back
   task automatic xfer(input logic [31:0] word, output logic [31:0] resp);
      select_load = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         serial_in = word[i];
         #32 link_clk = 1'b1;
         resp[i] = serial_out;
         #32 link_clk = 1'b0;
      end
      select_load = 1'b1;
      serial_in = ~serial_in; // Released line must not look like held data
      #240; // Gap lets the command execute and the answer load
   endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the over-temperature fault logic.
// Assumes the host model drives the link; sensors and clear pin change at clk falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import thermal_guard_pkg::*;
   logic       clk, reset_n, clear_pin_n, link_clk, select_load, serial_in, serial_out;
   logic       chip_off, alarm_n_out, alarm_n_oe, overheat_flag;
   logic [7:0] over_trip_in, below_release_in, channel_off;
   logic [31:0] r, v;
   int         errors, comparisons;
   thermal_shutdown_fault_logic dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
      .select_load(select_load), .serial_in(serial_in), .serial_out(serial_out), .clear_pin_n(clear_pin_n),
      .over_trip_in(over_trip_in), .below_release_in(below_release_in), .channel_off(channel_off),
      .chip_off(chip_off), .alarm_n_out(alarm_n_out), .alarm_n_oe(alarm_n_oe), .overheat_flag(overheat_flag));
   spi_host_model host (.link_clk(link_clk), .select_load(select_load), .serial_in(serial_in),
      .serial_out(serial_out));
   // 25 MHz system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] c, input logic [23:0] d);
      host.xfer({c, d}, r);
   endtask
   // A read answers in the following frame, which carries a no-op
   task automatic rd(input logic [7:0] c, output logic [31:0] q);
      cmd(c, 24'h0);
      host.xfer(32'h0, q);
   endtask
   // Sensor levels; five cycles cover the sync pipeline
   task automatic sense(input logic [7:0] hot, input logic [7:0] cool);
      @(negedge clk);
      over_trip_in = hot;
      below_release_in = cool;
      repeat (5) @(negedge clk);
   endtask
   function automatic logic [31:0] pack(input logic [7:0] c);
      pack = 32'h0;
      for (int i = 0; i < 8; i++) pack[8 + 2 * i] = c[i];
   endfunction
   task automatic t_reset;
      chk("alarm_n_out", 32'h1, alarm_n_out);
      chk("overheat_flag", 32'h0, overheat_flag);
      rd(CMD_CONFIG_RD, v);
      chk("config", 32'h0, v);
      $display("t_reset done");
   endtask
   task automatic t_trip;
      sense(8'h04, 8'h00);
      chk("channel_off", 32'h4, channel_off);
      chk("overheat_flag", 32'h1, overheat_flag);
      chk("alarm_n_oe", 32'h1, alarm_n_oe);
      chk("chip_off", 32'h0, chip_off);
      rd(CMD_STATUS_RD, v);
      chk("status", pack(8'h04), v);
      rd(CMD_PD_RD, v);
      chk("power_down", pack(8'h04), v);
      rd(CMD_FAULT_RD, v);
      chk("fault", 32'h400, v);
      chk("alarm_n_oe", 32'h0, alarm_n_oe);
      $display("t_trip done");
   endtask
   task automatic t_latch;
      sense(8'h00, 8'hFB);
      cmd(CMD_FAULT_WR, 24'h0);
      cmd(CMD_PD_WR, 24'h0);
      chk("channel_off", 32'h4, channel_off);
      sense(8'h00, 8'hFF);
      cmd(CMD_FAULT_WR, 24'h0);
      chk("overheat_flag", 32'h0, overheat_flag);
      cmd(CMD_PD_WR, 24'h0);
      chk("channel_off", 32'h0, channel_off);
      $display("t_latch done");
   endtask
   task automatic t_all;
      sense(8'hFF, 8'h00);
      chk("channel_off", 32'hFF, channel_off);
      chk("chip_off", 32'h1, chip_off);
      sense(8'h00, 8'hFF);
      cmd(CMD_CONFIG_WR, 24'h800000);
      chk("channel_off", 32'h0, channel_off);
      chk("chip_off", 32'h0, chip_off);
      chk("overheat_flag", 32'h0, overheat_flag);
      rd(CMD_STATUS_RD, v);
      chk("status", 32'h0, v);
      $display("t_all done");
   endtask
   task automatic t_clear;
      sense(8'h21, 8'h00);
      sense(8'h00, 8'hFF);
      chk("channel_off", 32'h21, channel_off);
      clear_pin_n = 1'b0;
      repeat (6) @(negedge clk);
      clear_pin_n = 1'b1;
      chk("channel_off", 32'h0, channel_off);
      chk("overheat_flag", 32'h0, overheat_flag);
      $display("t_clear done");
   endtask
   task automatic t_guard;
      cmd(CMD_CONFIG_WR, 24'h000700);
      rd(CMD_CONFIG_RD, v);
      chk("config", 32'h700, v);
      sense(8'h02, 8'h00);
      chk("channel_off", 32'h0, channel_off);
      chk("overheat_flag", 32'h0, overheat_flag);
      sense(8'h00, 8'hFF);
      cmd(CMD_CONFIG_WR, 24'h0);
      $display("t_guard done");
   endtask
   task automatic close_out;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Main sequence: reset for ten cycles, then the scenarios
   initial begin
      reset_n = 1'b0;
      clear_pin_n = 1'b1;
      over_trip_in = 8'h00;
      below_release_in = 8'hFF;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      t_reset();
      t_trip();
      t_latch();
      t_all();
      t_clear();
      t_guard();
      close_out();
   end
   // Scenarios need about 46 us; a hang stops well after that
   initial begin
      #500000;
      errors++;
      close_out();
   end
endmodule
`default_nettype wire
